/* design/mcr_pkg.sv */
package mcr_pkg;
	// register indices on the serial port (page-local addresses)
	localparam logic [5:0]  ADDR_PHASE_COMP   = 6'h05;
	localparam logic [5:0]  ADDR_SERIAL_CTRL  = 6'h07;
	localparam logic [5:0]  ADDR_PULSE_WIDTH  = 6'h08;
	localparam logic [5:0]  ADDR_PULSE_SRC    = 6'h09;
	localparam logic [5:0]  ADDR_PULSE_RATE   = 6'h1C;
	localparam logic [5:0]  ADDR_WP_KEYS      = 6'h22;
	localparam logic [5:0]  ADDR_ZX_COUNT     = 6'h37;
	localparam logic [5:0]  ADDR_STATUS0      = 6'h17;
	localparam logic [5:0]  ADDR_STATUS1      = 6'h18;
	localparam logic [5:0]  ADDR_STATUS2      = 6'h19;

	// reset values
	localparam logic [23:0] RST_PHASE_COMP    = 24'h000000;
	localparam logic [23:0] RST_SERIAL_CTRL   = 24'h02004D;
	localparam logic [23:0] RST_PULSE_WIDTH   = 24'h000001;
	localparam logic [23:0] RST_PULSE_SRC     = 24'h000000;
	localparam logic [23:0] RST_PULSE_RATE    = 24'h800000;
	localparam logic [23:0] RST_WP_KEYS       = 24'h000000;
	localparam logic [23:0] RST_ZX_COUNT      = 24'h000064;

	// field positions
	localparam int FINE1_LSB   = 0;
	localparam int FINE2_LSB   = 9;
	localparam int FINE_W      = 9;
	localparam int COARSE1_LSB = 20;
	localparam int COARSE2_LSB = 22;
	localparam int BAUD_LSB    = 0;
	localparam int BAUD_W      = 16;
	localparam int CSUM_OFF_BIT = 17;
	localparam int PULLUP_OFF_BIT = 18;
	localparam int PW_LSB      = 0;
	localparam int PW_W        = 16;
	localparam int RNG_LSB     = 16;
	localparam int SRC_W       = 4;
	localparam int KEY_HOST_LSB = 0;
	localparam int KEY_ENG_LSB = 8;
	localparam int KEY_W       = 5;

	// field masks for storage (reserved bits read as zero)
	localparam logic [23:0] MASK_PHASE_COMP   = 24'hF3FFFF;
	localparam logic [23:0] MASK_SERIAL_CTRL  = 24'h06FFFF;
	localparam logic [23:0] MASK_PULSE_WIDTH  = 24'h0FFFFF;
	localparam logic [23:0] MASK_PULSE_SRC    = 24'h000FFF;
	localparam logic [23:0] MASK_WP_KEYS      = 24'h001F1F;

	// lock keys
	localparam logic [4:0]  KEY_LOCK          = 5'h16;
	localparam logic [4:0]  KEY_UNLOCK        = 5'h09;

	// coarse phase codes
	localparam logic [1:0]  CP_NONE           = 2'h0;
	localparam logic [1:0]  CP_CUR_ONE        = 2'h1;
	localparam logic [1:0]  CP_VOLT_ONE       = 2'h2;
	localparam logic [1:0]  CP_VOLT_TWO       = 2'h3;

	// pulse frequency range: codes above this are reserved
	localparam logic [3:0]  RNG_MAX           = 4'h9;
	localparam int          ACC_BASE_W        = 24;
	localparam int          ACC_W             = 34;
	localparam logic [3:0]  SRC_MAX           = 4'h8;
	localparam int          NUM_GEN           = 3;

	// pulse timing at the 25 MHz core clock
	localparam int          CLK_HZ            = 25_000_000;
	localparam int          PULSE_BASE_US     = 250;
	localparam int          PULSE_BASE_CYC    = PULSE_BASE_US * (CLK_HZ / 1_000_000);
	localparam int          PW_DIVISOR        = 64_000;
	localparam int          PW_MUL            = CLK_HZ / 1000;
	localparam int          PW_SHIFT          = 6;
	localparam int          WIDTH_CYC_W       = 26;

	typedef logic signed [23:0] mcr_word_t;

	// power results that feed the pulse generators
	typedef struct packed {
		mcr_word_t p1;
		mcr_word_t p2;
		mcr_word_t psum;
		mcr_word_t q1;
		mcr_word_t q2;
		mcr_word_t qsum;
		mcr_word_t s1;
		mcr_word_t s2;
		mcr_word_t ssum;
	} mcr_power_t;

	// decoded phase settings for one channel pair
	typedef struct packed {
		logic [1:0]        cur_delay;
		logic [1:0]        volt_delay;
		logic [FINE_W-1:0] fine_delay;
	} mcr_phase_t;

	// write request from the serial command decoder or the engine
	typedef struct packed {
		logic        wr;
		logic [5:0]  addr;
		logic [23:0] data;
	} mcr_write_t;
endpackage : mcr_pkg

/* design/mcr_pulse_gen.sv */
`timescale 1ns/100ps
`default_nettype none
module mcr_pulse_gen
	import mcr_pkg::*;
(
	input  wire logic                   clk_in,
	input  wire logic                   resetn_in,
	input  wire logic                   enable_in,
	input  wire logic                   owr_tick_in,
	input  wire mcr_power_t             power_in,
	input  wire logic [SRC_W-1:0]       source_in,
	input  wire mcr_word_t              rate_in,
	input  wire logic [3:0]             range_in,
	input  wire logic [WIDTH_CYC_W-1:0] width_cyc_in,
	output logic                        pulse_out
);
	mcr_word_t               src_word;
	logic signed [47:0]      product;
	logic [23:0]             magnitude;
	logic [3:0]              rng;
	logic [ACC_W-1:0]        limit;
	logic [ACC_W-1:0]        acc;
	logic [ACC_W-1:0]        next_acc;
	logic [WIDTH_CYC_W-1:0]  width_cnt;

	always_comb begin
		case (source_in)
			4'h0: src_word = power_in.p1;
			4'h1: src_word = power_in.p2;
			4'h2: src_word = power_in.psum;
			4'h3: src_word = power_in.q1;
			4'h4: src_word = power_in.q2;
			4'h5: src_word = power_in.qsum;
			4'h6: src_word = power_in.s1;
			4'h7: src_word = power_in.s2;
			4'h8: src_word = power_in.ssum;
			default: src_word = '0; // unused codes give no energy
		endcase
	end

	// fractional full-scale scaling
	// the rate is a signed fraction, so the product keeps bits 46..23
	assign product   = src_word * rate_in;
	assign magnitude = product[47] ? 24'(-product[46:23]) : 24'(product[46:23]);

	// range halves maximum rate per code
	// reserved codes clamp to the slowest range rather than overflow the shift
	assign rng   = (range_in > RNG_MAX) ? RNG_MAX : range_in;
	assign limit = ACC_W'(1) << (ACC_BASE_W + int'(rng));

	always_comb begin
		next_acc = acc + ACC_W'(magnitude);
		if (next_acc >= limit) begin
			next_acc = next_acc - limit;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			acc <= '0;
		end else if (!enable_in) begin
			acc <= '0;
		end else if (owr_tick_in) begin
			acc <= next_acc;
		end
	end

	// pulse lasts programmed width
	// an overflow during a pulse restarts the width count
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			width_cnt <= '0;
			pulse_out <= 1'b0;
		end else if (!enable_in) begin
			width_cnt <= '0;
			pulse_out <= 1'b0;
		end else if (owr_tick_in && (acc + ACC_W'(magnitude) >= limit)) begin
			width_cnt <= width_cyc_in;
			pulse_out <= 1'b1;
		end else if (width_cnt > WIDTH_CYC_W'(1)) begin
			width_cnt <= width_cnt - WIDTH_CYC_W'(1);
		end else begin
			width_cnt <= '0;
			pulse_out <= 1'b0;
		end
	end
endmodule : mcr_pulse_gen
`default_nettype wire

/* design/mcr_config_regs.sv */
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - coarse code: 00 none, 01 current +1 word, 10 voltage +1, 11 voltage +2
// - 9-bit fine field delays current versus voltage in fine steps
// - receive pull-up stays on while its disable bit is zero
// - checksum checking off while its bit is one, which is reset value
// - baud rate follows the 16-bit divisor field
// - pulse lasts 250 us plus width value over 64000 seconds
// - range code 0 gives 2 kHz maximum, halving per code to 1001
// - zero-crossing count resets to 100; host keeps it 1 to 8388607
// - full-scale rate is a signed fraction from -1 to below 1
// - source codes 0..8 pick P1,P2,Psum,Q1,Q2,Qsum,S1,S2,Ssum
// - engine key 0x16 blocks engine writes, 0x09 releases them
// - host key 0x16 blocks serial writes except to the lock register
// - each generator runs only with its enable set; all off at reset
module mcr_config_regs
	import mcr_pkg::*;
#(
	parameter int PULSE_BASE_CYCLES = PULSE_BASE_CYC
)(
	input  wire logic                   CORE_CLK_IN,
	input  wire logic                   RESETN_IN,
	input  wire mcr_write_t             HOST_WRITE_IN,
	input  wire logic                   HOST_RD_IN,
	input  wire logic [5:0]             HOST_RD_ADDR_IN,
	input  wire mcr_write_t             ENGINE_WRITE_IN,
	input  wire logic [NUM_GEN-1:0]     GEN_ENABLE_IN,
	input  wire logic                   OWR_TICK_IN,
	input  wire mcr_power_t             POWER_IN,
	output logic [23:0]                 HOST_RD_DATA_OUT,
	output var mcr_phase_t              PHASE_PAIR_ONE_OUT,
	output var mcr_phase_t              PHASE_PAIR_TWO_OUT,
	output logic [BAUD_W-1:0]           BAUD_DIVISOR_OUT,
	output logic                        RX_PULLUP_ENABLE_OUT,
	output logic                        RX_CHECKSUM_ENABLE_OUT,
	output logic [23:0]                 ZERO_CROSS_COUNT_OUT,
	output logic                        HOST_LOCKED_OUT,
	output logic                        ENGINE_LOCKED_OUT,
	output logic [NUM_GEN-1:0]          PULSE_OUT
);
	logic [23:0]            phase_compensation;
	logic [23:0]            serial_port_control;
	logic [23:0]            pulse_width_and_range;
	logic [23:0]            pulse_source_select;
	logic [23:0]            pulse_full_scale_rate;
	logic [23:0]            write_protect_keys;
	logic [23:0]            zero_cross_count;
	logic                   host_locked;
	logic                   engine_locked;
	logic                   host_ok;
	logic                   eng_ok;
	logic [4:0]             host_key;
	logic [4:0]             engine_key;
	logic [PW_W-1:0]        pulse_width_value;
	logic [WIDTH_CYC_W-1:0] width_cyc;
	logic [31:0]            width_extra;

	// host writes gated by host lock
	// the lock register itself stays writable so software can always unlock
	assign host_ok = HOST_WRITE_IN.wr && (!host_locked || HOST_WRITE_IN.addr == ADDR_WP_KEYS);
	// engine writes gated by engine lock
	// a host write in the same cycle takes precedence over the engine
	assign eng_ok  = ENGINE_WRITE_IN.wr && !engine_locked
		&& !(host_ok && HOST_WRITE_IN.addr == ENGINE_WRITE_IN.addr);

	assign host_key   = HOST_WRITE_IN.data[KEY_HOST_LSB +: KEY_W];
	assign engine_key = HOST_WRITE_IN.data[KEY_ENG_LSB +: KEY_W];

	// phase compensation, lockable against the engine (calibration result)
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			phase_compensation <= RST_PHASE_COMP;
		end else if (host_ok && HOST_WRITE_IN.addr == ADDR_PHASE_COMP) begin
			phase_compensation <= HOST_WRITE_IN.data & MASK_PHASE_COMP;
		end else if (eng_ok && ENGINE_WRITE_IN.addr == ADDR_PHASE_COMP) begin
			phase_compensation <= ENGINE_WRITE_IN.data & MASK_PHASE_COMP;
		end
	end

	// full-scale rate, also lockable against the engine
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			pulse_full_scale_rate <= RST_PULSE_RATE;
		end else if (host_ok && HOST_WRITE_IN.addr == ADDR_PULSE_RATE) begin
			pulse_full_scale_rate <= HOST_WRITE_IN.data;
		end else if (eng_ok && ENGINE_WRITE_IN.addr == ADDR_PULSE_RATE) begin
			pulse_full_scale_rate <= ENGINE_WRITE_IN.data;
		end
	end

	// host-only registers keep value when locked
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			serial_port_control   <= RST_SERIAL_CTRL;
			pulse_width_and_range <= RST_PULSE_WIDTH;
			pulse_source_select   <= RST_PULSE_SRC;
			zero_cross_count      <= RST_ZX_COUNT;
		end else if (host_ok) begin
			case (HOST_WRITE_IN.addr)
				ADDR_SERIAL_CTRL: begin
					serial_port_control <= HOST_WRITE_IN.data & MASK_SERIAL_CTRL;
				end
				ADDR_PULSE_WIDTH: begin
					pulse_width_and_range <= HOST_WRITE_IN.data & MASK_PULSE_WIDTH;
				end
				ADDR_PULSE_SRC: begin
					pulse_source_select <= HOST_WRITE_IN.data & MASK_PULSE_SRC;
				end
				ADDR_ZX_COUNT: begin
					zero_cross_count <= HOST_WRITE_IN.data;
				end
				default: begin
				end
			endcase
		end
	end

	// key register and the lock states; keys other than the two codes leave locks alone
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			write_protect_keys <= RST_WP_KEYS;
			host_locked        <= 1'b0;
			engine_locked      <= 1'b0;
		end else if (host_ok && HOST_WRITE_IN.addr == ADDR_WP_KEYS) begin
			write_protect_keys <= HOST_WRITE_IN.data & MASK_WP_KEYS;
			if (host_key == KEY_LOCK) begin
				host_locked <= 1'b1;
			end else if (host_key == KEY_UNLOCK) begin
				host_locked <= 1'b0;
			end
			if (engine_key == KEY_LOCK) begin
				engine_locked <= 1'b1;
			end else if (engine_key == KEY_UNLOCK) begin
				engine_locked <= 1'b0;
			end
		end
	end

	// reads return stored content
	// one cycle of latency; unmapped and status addresses read zero here
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			HOST_RD_DATA_OUT <= '0;
		end else if (HOST_RD_IN) begin
			case (HOST_RD_ADDR_IN)
				ADDR_PHASE_COMP:  HOST_RD_DATA_OUT <= phase_compensation;
				ADDR_SERIAL_CTRL: HOST_RD_DATA_OUT <= serial_port_control;
				ADDR_PULSE_WIDTH: HOST_RD_DATA_OUT <= pulse_width_and_range;
				ADDR_PULSE_SRC:   HOST_RD_DATA_OUT <= pulse_source_select;
				ADDR_PULSE_RATE:  HOST_RD_DATA_OUT <= pulse_full_scale_rate;
				ADDR_WP_KEYS:     HOST_RD_DATA_OUT <= write_protect_keys;
				ADDR_ZX_COUNT:    HOST_RD_DATA_OUT <= zero_cross_count;
				default:          HOST_RD_DATA_OUT <= '0;
			endcase
		end
	end

	function automatic mcr_phase_t decode_phase(input logic [1:0] coarse,
		input logic [FINE_W-1:0] fine);
		mcr_phase_t p;
		p.fine_delay = fine;
		case (coarse)
			CP_CUR_ONE:  begin p.cur_delay = 2'h1; p.volt_delay = 2'h0; end
			CP_VOLT_ONE: begin p.cur_delay = 2'h0; p.volt_delay = 2'h1; end
			CP_VOLT_TWO: begin p.cur_delay = 2'h0; p.volt_delay = 2'h2; end
			default:     begin p.cur_delay = 2'h0; p.volt_delay = 2'h0; end
		endcase
		return p;
	endfunction : decode_phase

	// control outputs registered so the datapath sees clean levels
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			PHASE_PAIR_ONE_OUT     <= '0;
			PHASE_PAIR_TWO_OUT     <= '0;
			BAUD_DIVISOR_OUT       <= RST_SERIAL_CTRL[BAUD_LSB +: BAUD_W];
			RX_PULLUP_ENABLE_OUT   <= 1'b1;
			RX_CHECKSUM_ENABLE_OUT <= 1'b0;
			ZERO_CROSS_COUNT_OUT   <= RST_ZX_COUNT;
			HOST_LOCKED_OUT        <= 1'b0;
			ENGINE_LOCKED_OUT      <= 1'b0;
		end else begin
			PHASE_PAIR_ONE_OUT <= decode_phase(phase_compensation[COARSE1_LSB +: 2],
				phase_compensation[FINE1_LSB +: FINE_W]);
			PHASE_PAIR_TWO_OUT <= decode_phase(phase_compensation[COARSE2_LSB +: 2],
				phase_compensation[FINE2_LSB +: FINE_W]);
			BAUD_DIVISOR_OUT       <= serial_port_control[BAUD_LSB +: BAUD_W];
			RX_PULLUP_ENABLE_OUT   <= !serial_port_control[PULLUP_OFF_BIT];
			RX_CHECKSUM_ENABLE_OUT <= !serial_port_control[CSUM_OFF_BIT];
			ZERO_CROSS_COUNT_OUT   <= zero_cross_count;
			HOST_LOCKED_OUT        <= host_locked;
			ENGINE_LOCKED_OUT      <= engine_locked;
		end
	end

	// width zero not guarded
	// zero simply gives the bare base width
	assign pulse_width_value = pulse_width_and_range[PW_LSB +: PW_W];
	assign width_extra = (32'(pulse_width_value) * 32'(PW_MUL)) >> PW_SHIFT;
	assign width_cyc   = WIDTH_CYC_W'(PULSE_BASE_CYCLES) + width_extra[WIDTH_CYC_W-1:0];

	// three identical generators
	for (genvar g = 0; g < NUM_GEN; g++) begin : gen_pulse
		mcr_pulse_gen u_gen (
			.clk_in       (CORE_CLK_IN),
			.resetn_in    (RESETN_IN),
			.enable_in    (GEN_ENABLE_IN[g]),
			.owr_tick_in  (OWR_TICK_IN),
			.power_in     (POWER_IN),
			.source_in    (pulse_source_select[g*SRC_W +: SRC_W]),
			.rate_in      (pulse_full_scale_rate),
			.range_in     (pulse_width_and_range[RNG_LSB +: 4]),
			.width_cyc_in (width_cyc),
			.pulse_out    (PULSE_OUT[g])
		);
	end
endmodule : mcr_config_regs
`default_nettype wire

/* testbench/mcr_config_regs_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// watches lock handling, control outputs and pulse gating at the top-level ports
module mcr_config_regs_checker
	import mcr_pkg::*;
#(
	parameter int PULSE_BASE_CYCLES = PULSE_BASE_CYC
)(
	input  wire logic               CORE_CLK_IN,
	input  wire logic               RESETN_IN,
	input  wire mcr_write_t         HOST_WRITE_IN,
	input  wire logic               HOST_RD_IN,
	input  wire logic [5:0]         HOST_RD_ADDR_IN,
	input  wire logic [NUM_GEN-1:0] GEN_ENABLE_IN,
	input  wire logic [23:0]        HOST_RD_DATA_OUT,
	input  wire mcr_phase_t         PHASE_PAIR_ONE_OUT,
	input  wire logic [BAUD_W-1:0]  BAUD_DIVISOR_OUT,
	input  wire logic               RX_PULLUP_ENABLE_OUT,
	input  wire logic               RX_CHECKSUM_ENABLE_OUT,
	input  wire logic               HOST_LOCKED_OUT,
	input  wire logic               ENGINE_LOCKED_OUT,
	input  wire logic [NUM_GEN-1:0] PULSE_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	// decoded host writes; a key write one cycle back may still be landing
	wire key_wr  = HOST_WRITE_IN.wr && HOST_WRITE_IN.addr == ADDR_WP_KEYS;
	wire ctrl_wr = HOST_WRITE_IN.wr && HOST_WRITE_IN.addr == ADDR_SERIAL_CTRL;
	wire ph_wr   = HOST_WRITE_IN.wr && HOST_WRITE_IN.addr == ADDR_PHASE_COMP;
	// high-time count of generator one's pulse, cleared the cycle after the pin goes low
	int  hi_cnt;
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			hi_cnt <= 0;
		end else begin
			hi_cnt <= PULSE_OUT[0] ? hi_cnt + 1 : 0;
		end
	end

	a_serial_ctrl_update:
	assert property (ctrl_wr && !HOST_LOCKED_OUT && !$past(key_wr) |-> ##2
		BAUD_DIVISOR_OUT == $past(HOST_WRITE_IN.data[15:0], 2) &&
		RX_PULLUP_ENABLE_OUT == !$past(HOST_WRITE_IN.data[18], 2) &&
		RX_CHECKSUM_ENABLE_OUT == !$past(HOST_WRITE_IN.data[17], 2))
		else $error("serial control outputs do not follow write");
	a_host_lock_key:
	assert property (key_wr && HOST_WRITE_IN.data[4:0] == KEY_LOCK |-> ##2 HOST_LOCKED_OUT)
		else $error("host lock key did not lock");
	a_host_unlock_key:
	assert property (key_wr && HOST_WRITE_IN.data[4:0] == KEY_UNLOCK |-> ##2 !HOST_LOCKED_OUT)
		else $error("host unlock key did not unlock");
	a_engine_lock_key:
	assert property (key_wr && HOST_WRITE_IN.data[12:8] == KEY_LOCK |-> ##2 ENGINE_LOCKED_OUT)
		else $error("engine lock key did not lock");
	a_locked_write_dropped:
	assert property ((ctrl_wr && HOST_LOCKED_OUT) ##1 HOST_LOCKED_OUT |->
		$stable(BAUD_DIVISOR_OUT) [*2])
		else $error("locked write changed baud divisor");
	a_status_read_zero:
	assert property (HOST_RD_IN && HOST_RD_ADDR_IN == ADDR_STATUS0 |=> HOST_RD_DATA_OUT == 24'h0)
		else $error("status read not zero");
	a_read_data_holds:
	assert property (!HOST_RD_IN |=> $stable(HOST_RD_DATA_OUT))
		else $error("read data moved without a read");
	a_coarse_volt_two:
	assert property (ph_wr && !HOST_LOCKED_OUT && !$past(key_wr) &&
		HOST_WRITE_IN.data[21:20] == CP_VOLT_TWO |-> ##2
		PHASE_PAIR_ONE_OUT.volt_delay == 2'h2 && PHASE_PAIR_ONE_OUT.cur_delay == 2'h0)
		else $error("coarse code three wrongly decoded");
	a_pulse_disable:
	assert property (!GEN_ENABLE_IN[0] |=> !PULSE_OUT[0])
		else $error("pulse while generator disabled");
	// a disable may cut a pulse short, so only pulses that end while enabled count
	a_pulse_min_width:
	assert property ($fell(PULSE_OUT[0]) && $past(GEN_ENABLE_IN[0]) |->
		hi_cnt >= PULSE_BASE_CYCLES)
		else $error("pulse shorter than the base width");
endmodule : mcr_config_regs_checker
bind mcr_config_regs mcr_config_regs_checker #(
	.PULSE_BASE_CYCLES(PULSE_BASE_CYCLES)
) chk (
	.CORE_CLK_IN(CORE_CLK_IN), .RESETN_IN(RESETN_IN), .HOST_WRITE_IN(HOST_WRITE_IN),
	.HOST_RD_IN(HOST_RD_IN), .HOST_RD_ADDR_IN(HOST_RD_ADDR_IN), .GEN_ENABLE_IN(GEN_ENABLE_IN),
	.HOST_RD_DATA_OUT(HOST_RD_DATA_OUT), .PHASE_PAIR_ONE_OUT(PHASE_PAIR_ONE_OUT),
	.BAUD_DIVISOR_OUT(BAUD_DIVISOR_OUT), .RX_PULLUP_ENABLE_OUT(RX_PULLUP_ENABLE_OUT),
	.RX_CHECKSUM_ENABLE_OUT(RX_CHECKSUM_ENABLE_OUT), .HOST_LOCKED_OUT(HOST_LOCKED_OUT),
	.ENGINE_LOCKED_OUT(ENGINE_LOCKED_OUT), .PULSE_OUT(PULSE_OUT)
);
`default_nettype wire

/* testbench/mcr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// host side of the register port: one access at a time, launched just after an edge
module mcr_host_model
	import mcr_pkg::*;
(
	input  wire logic        clk_in,
	output var  mcr_write_t  wr_out,
	output logic             rd_out,
	output logic [5:0]       rd_addr_out,
	input  wire logic [23:0] rd_data_in
);
	// idle port before the first access
	initial begin
		wr_out = '{wr: 1'b0, addr: 6'h3F, data: 24'h0};
		rd_out = 1'b0;
		rd_addr_out = 6'h3F;
	end
	// released fields are inverted so a stale value never passes for a live one
	task automatic write_reg(input logic [5:0] a, input logic [23:0] d);
		logic [23:0] v;
		v = d;
		if ((a == ADDR_PULSE_WIDTH && v[15:0] == 16'h0) || (a == ADDR_ZX_COUNT && v == 24'h0))
			v[0] = 1'b1;
		@(posedge clk_in);
		#1;
		wr_out = '{wr: 1'b1, addr: a, data: v};
		@(posedge clk_in);
		#1;
		wr_out = '{wr: 1'b0, addr: ~a, data: ~v};
	endtask : write_reg
	// data is taken one cycle after the strobe edge
	task automatic read_reg(input logic [5:0] a, output logic [23:0] d);
		@(posedge clk_in);
		#1;
		rd_out = 1'b1;
		rd_addr_out = a;
		@(posedge clk_in);
		#1;
		d = rd_data_in;
		rd_out = 1'b0;
		rd_addr_out = ~a;
	endtask : read_reg
endmodule : mcr_host_model
`default_nettype wire

/* testbench/tb_mcr_config_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_mcr_config_regs
	import mcr_pkg::*;
;
	localparam int PB = 20; // short base width keeps the run brief
	logic               core_clk = 1'b0;
	logic               resetn = 1'b0;
	mcr_write_t         host_wr;
	mcr_write_t         eng_wr = '0;
	logic               host_rd;
	logic [5:0]         rd_addr;
	logic [NUM_GEN-1:0] gen_en = '0;
	logic               owr_tick = 1'b0;
	mcr_power_t         power = '0;
	logic [23:0]        rd_data, rd_v, zx;
	mcr_phase_t         ph1, ph2;
	logic [BAUD_W-1:0]  baud;
	logic               pu_en, cs_en, hlock, elock;
	logic [NUM_GEN-1:0] pulse;
	int                 error_cnt = 0, n_compared = 0, cycles = 0;
	logic [5:0]  adr [7] = '{ADDR_PHASE_COMP, ADDR_SERIAL_CTRL, ADDR_PULSE_WIDTH, ADDR_PULSE_SRC,
		ADDR_PULSE_RATE, ADDR_WP_KEYS, ADDR_ZX_COUNT};
	logic [23:0] rst [7] = '{RST_PHASE_COMP, RST_SERIAL_CTRL, RST_PULSE_WIDTH, RST_PULSE_SRC,
		RST_PULSE_RATE, RST_WP_KEYS, RST_ZX_COUNT};
	logic [23:0] msk [7] = '{MASK_PHASE_COMP, MASK_SERIAL_CTRL, MASK_PULSE_WIDTH, MASK_PULSE_SRC,
		24'hFFFFFF, MASK_WP_KEYS, 24'hFFFFFF};

	mcr_config_regs #(
		.PULSE_BASE_CYCLES(PB)
	) dut (
		.CORE_CLK_IN(core_clk), .RESETN_IN(resetn), .HOST_WRITE_IN(host_wr),
		.HOST_RD_IN(host_rd), .HOST_RD_ADDR_IN(rd_addr), .ENGINE_WRITE_IN(eng_wr),
		.GEN_ENABLE_IN(gen_en), .OWR_TICK_IN(owr_tick), .POWER_IN(power),
		.HOST_RD_DATA_OUT(rd_data), .PHASE_PAIR_ONE_OUT(ph1), .PHASE_PAIR_TWO_OUT(ph2),
		.BAUD_DIVISOR_OUT(baud), .RX_PULLUP_ENABLE_OUT(pu_en), .RX_CHECKSUM_ENABLE_OUT(cs_en),
		.ZERO_CROSS_COUNT_OUT(zx), .HOST_LOCKED_OUT(hlock), .ENGINE_LOCKED_OUT(elock),
		.PULSE_OUT(pulse)
	);
	mcr_host_model hm (
		.clk_in(core_clk), .wr_out(host_wr), .rd_out(host_rd), .rd_addr_out(rd_addr),
		.rd_data_in(rd_data)
	);

	// 25 MHz clock
	always #20 core_clk = ~core_clk;
	// hang guard, well above the roughly 5200 cycles the tests need
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk_word(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_word
	task automatic chk_count(input string nm, input int e, input int g);
		n_compared++;
		if (g != e) begin
			error_cnt++;
			$display("mismatch %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk_count
	task automatic cyc();
		@(posedge core_clk);
		#1;
	endtask : cyc
	task automatic rd_chk(input logic [5:0] a, input logic [23:0] e);
		hm.read_reg(a, rd_v);
		chk_word($sformatf("register %h", a), e, rd_v);
	endtask : rd_chk
	task automatic eng_write(input logic [5:0] a, input logic [23:0] d);
		cyc();
		eng_wr = '{wr: 1'b1, addr: a, data: d};
		cyc();
		eng_wr = '{wr: 1'b0, addr: ~a, data: ~d};
	endtask : eng_write
	function automatic mcr_phase_t exp_ph(input logic [1:0] code, input logic [8:0] f);
		exp_ph.cur_delay = (code == 2'h1) ? 2'h1 : 2'h0;
		exp_ph.volt_delay = (code == 2'h2) ? 2'h1 : ((code == 2'h3) ? 2'h2 : 2'h0);
		exp_ph.fine_delay = f;
	endfunction : exp_ph
	// source word 0.5 on selected input only, on every input for code 9; n ticks must precede the pulse
	task automatic pulse_try(input int g, input int k, input int n, input int w);
		int cnt;
		cnt = 0;
		// unused code 9 sees every source live, so only the decode holds the pulse off
		power = '0;
		if (k < 9)
			power[(8 - k) * 24 +: 24] = 24'h400000;
		else
			power = {9{24'h400000}};
		hm.write_reg(ADDR_PULSE_SRC, 24'(k) << (4 * g));
		gen_en = NUM_GEN'(1 << g);
		repeat (n) begin
			chk_word("early pulse", 24'h0, 24'(pulse));
			cyc();
			owr_tick = 1'b1;
			cyc();
			owr_tick = 1'b0;
		end
		repeat (3) if (pulse[g] !== 1'b1) cyc();
		while (pulse[g] === 1'b1 && cnt < 30000) begin
			cnt++;
			cyc();
		end
		chk_count("pulse width", w, cnt);
		gen_en = '0;
		cyc();
	endtask : pulse_try

	// main sequence
	initial begin
		repeat (4) @(posedge core_clk);
		#1;
		resetn = 1'b1;
		for (int i = 0; i < 7; i++) rd_chk(adr[i], rst[i]);
		chk_word("control outputs", {4'h0, 16'h004D, 4'h8}, {4'h0, baud, pu_en, cs_en, hlock, elock});
		chk_word("zero cross count", 24'h000064, zx);
		for (int i = 0; i < 7; i++) hm.write_reg(adr[i], 24'hFFFFFF);
		for (int i = 0; i < 7; i++) rd_chk(adr[i], msk[i]);
		rd_chk(6'h3F, 24'h0);
		rd_chk(ADDR_STATUS0, 24'h0);
		chk_word("control outputs", {4'h0, 16'hFFFF, 4'h0}, {4'h0, baud, pu_en, cs_en, hlock, elock});
		hm.write_reg(ADDR_SERIAL_CTRL, 24'h000123);
		cyc();
		chk_word("control outputs", {4'h0, 16'h0123, 4'hC}, {4'h0, baud, pu_en, cs_en, hlock, elock});
		for (int c = 0; c < 4; c++) begin
			hm.write_reg(ADDR_PHASE_COMP, {2'(3 - c), 2'(c), 2'h0, 9'(9'h0AA + c), 9'(9'h100 >> c)});
			cyc();
			chk_word("pair one", 24'(exp_ph(2'(c), 9'(9'h100 >> c))), 24'(ph1));
			chk_word("pair two", 24'(exp_ph(2'(3 - c), 9'(9'h0AA + c))), 24'(ph2));
		end
		// host lock drops writes until the unlock key
		hm.write_reg(ADDR_WP_KEYS, 24'h000016);
		hm.write_reg(ADDR_ZX_COUNT, 24'h000005);
		hm.write_reg(ADDR_SERIAL_CTRL, 24'h000000);
		hm.write_reg(ADDR_WP_KEYS, 24'h000003);
		cyc();
		chk_word("control outputs", {4'h0, 16'h0123, 4'hE}, {4'h0, baud, pu_en, cs_en, hlock, elock});
		rd_chk(ADDR_ZX_COUNT, 24'hFFFFFF);
		hm.write_reg(ADDR_WP_KEYS, 24'h000009);
		hm.write_reg(ADDR_ZX_COUNT, 24'h000005);
		cyc();
		chk_word("zero cross count", 24'h000005, zx);
		// engine lock blocks the engine path only
		eng_write(ADDR_PULSE_RATE, 24'h123456);
		rd_chk(ADDR_PULSE_RATE, 24'h123456);
		hm.write_reg(ADDR_WP_KEYS, 24'h001600);
		eng_write(ADDR_PULSE_RATE, 24'h654321);
		rd_chk(ADDR_PULSE_RATE, 24'h123456);
		chk_word("engine lock", 24'h1, 24'(elock));
		hm.write_reg(ADDR_WP_KEYS, 24'h000900);
		eng_write(ADDR_PULSE_RATE, 24'h800000);
		rd_chk(ADDR_PULSE_RATE, 24'h800000);
		// pulse generators: source codes 0 to 9, two ranges, two rates
		hm.write_reg(ADDR_PULSE_WIDTH, 24'h000001);
		for (int k = 0; k < 10; k++) pulse_try(k % 3, k, 4, (k < 9) ? PB + 390 : 0);
		hm.write_reg(ADDR_PULSE_WIDTH, 24'h010002);
		pulse_try(0, 0, 8, PB + 781);
		hm.write_reg(ADDR_PULSE_WIDTH, 24'h000001);
		hm.write_reg(ADDR_PULSE_RATE, 24'h400000);
		pulse_try(2, 4, 8, PB + 390);
		complete_run();
	end
endmodule : tb_mcr_config_regs
`default_nettype wire
